// >>> dv/tb_top.sv
// Purpose: Self-checking bench for the fault protection block
// Assumes: 10 MHz clock, inputs driven 10 ns after each rising edge
// Notes: Regulator 1 undervoltage latch needs 16.4 ms of soft start, beyond run length
`timescale 1ns/10ps
module tb_top;
    // ---------------------------------------------
    // Signals and instance
    // ---------------------------------------------
    logic clk, rst_b, thermal_shutdown, bridge_oc, reg1_oc, reg2_oc, reg1_uv, reg2_uv;
    logic reg2_supply_low, sleep, reg1_enable_n, reg2_enable_n;
    logic reg1_cycle_start, reg2_cycle_start;
    logic bridge_on, aux_on, reg1_on, reg2_on, reg2_high_side_ok;
    logic reg1_ss_done, reg2_ss_done, overcurrent_flag_out;
    int bad_count = 0;
    int cmp_count = 0;
    int n;

    fault_prot fault_prot_i (.clk(clk), .rst_b(rst_b), .thermal_shutdown(thermal_shutdown),
        .bridge_oc(bridge_oc), .reg1_oc(reg1_oc), .reg2_oc(reg2_oc), .reg1_uv(reg1_uv),
        .reg2_uv(reg2_uv), .reg2_supply_low(reg2_supply_low), .sleep(sleep),
        .reg1_enable_n(reg1_enable_n), .reg2_enable_n(reg2_enable_n),
        .reg1_cycle_start(reg1_cycle_start), .reg2_cycle_start(reg2_cycle_start),
        .bridge_on(bridge_on), .aux_on(aux_on), .reg1_on(reg1_on), .reg2_on(reg2_on),
        .reg2_high_side_ok(reg2_high_side_ok), .reg1_ss_done(reg1_ss_done),
        .reg2_ss_done(reg2_ss_done), .overcurrent_flag_out(overcurrent_flag_out));

    // Free-running 100 ns clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ---------------------------------------------
    // Shared helpers
    // ---------------------------------------------
    // Let n edges pass, then settle past the drive point
    task automatic step(input int cycles);
        repeat (cycles) @(posedge clk);
        #10;
    endtask

    task automatic check(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %b seen %b", what, exp, got);
            bad_count++;
        end
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Idle inputs, reset held for 8 cycles
    task automatic do_reset();
        {thermal_shutdown, bridge_oc, reg1_oc, reg2_oc, reg1_uv, reg2_uv} = 6'h00;
        {reg2_supply_low, reg1_enable_n, reg2_enable_n} = 3'h0;
        {reg1_cycle_start, reg2_cycle_start} = 2'h0;
        sleep = 1'b1;
        rst_b = 1'b0;
        step(8);
        rst_b = 1'b1;
        step(1);
    endtask

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic test_thermal();
        do_reset();
        thermal_shutdown = 1'b1;
        step(1);
        check("bridge_on", 1'b0, bridge_on);
        check("aux_on", 1'b0, aux_on);
        check("reg1_on", 1'b0, reg1_on);
        check("reg2_on", 1'b0, reg2_on);
        thermal_shutdown = 1'b0;
        step(20);
        check("reg1_on held", 1'b0, reg1_on);
        do_reset();
        check("bridge_on", 1'b1, bridge_on);
        check("reg2_on", 1'b1, reg2_on);
        $display("thermal test done");
    endtask

    task automatic test_bridge();
        do_reset();
        bridge_oc = 1'b1;
        n = 0;
        while (bridge_on === 1'b1 && n < 40)
        begin
            step(1);
            n++;
        end
        check("bridge mask", 1'b1, n >= 29 && n <= 33);
        check("flag out", 1'b0, overcurrent_flag_out);
        bridge_oc = 1'b0;
        step(5);
        check("bridge latched", 1'b0, bridge_on);
        sleep = 1'b0;
        step(5);
        check("bridge after low", 1'b0, bridge_on);
        sleep = 1'b1;
        step(2);
        check("bridge restored", 1'b1, bridge_on);
        check("flag out", 1'b1, overcurrent_flag_out);
        $display("bridge test done");
    endtask

    task automatic test_reg1_oc();
        do_reset();
        reg1_oc = 1'b1;
        step(1);
        reg1_oc = 1'b0;
        step(3);
        check("reg1 short glitch", 1'b1, reg1_on);
        reg1_oc = 1'b1;
        step(3);
        reg1_oc = 1'b0;
        check("reg1 tripped", 1'b0, reg1_on);
        step(2540);
        check("reg1 off span", 1'b0, reg1_on);
        step(200);
        check("reg1 waits edge", 1'b0, reg1_on);
        reg1_cycle_start = 1'b1;
        step(1);
        reg1_cycle_start = 1'b0;
        step(1);
        check("reg1 resumed", 1'b1, reg1_on);
        $display("reg1 overcurrent test done");
    endtask

    task automatic test_reg2_oc();
        do_reset();
        reg2_oc = 1'b1;
        #1;
        check("high side cut", 1'b0, reg2_high_side_ok);
        step(1);
        reg2_oc = 1'b0;
        step(3);
        check("high side rest", 1'b0, reg2_high_side_ok);
        reg2_cycle_start = 1'b1;
        step(1);
        reg2_cycle_start = 1'b0;
        step(1);
        check("high side back", 1'b1, reg2_high_side_ok);
        reg2_supply_low = 1'b1;
        step(2);
        check("reg2 lockout", 1'b0, reg2_on);
        reg2_supply_low = 1'b0;
        step(2);
        check("reg2 unlocked", 1'b1, reg2_on);
        $display("reg2 overcurrent and lockout test done");
    endtask

    task automatic test_reg2_uv();
        do_reset();
        n = 0;
        while (reg2_ss_done !== 1'b1 && n < 12000)
        begin
            step(1);
            n++;
        end
        if (n >= 12000)
        begin
            bad_count++;
            end_of_test();
        end
        check("reg2 soft start", 1'b1, n >= 9900 && n <= 10100);
        reg2_uv = 1'b1;
        step(5000);
        reg2_uv = 1'b0;
        step(1);
        reg2_uv = 1'b1;
        step(9000);
        check("reg2 uv restart", 1'b1, reg2_on);
        step(1100);
        check("reg2 uv off", 1'b0, reg2_on);
        reg2_uv = 1'b0;
        step(50);
        check("reg2 uv held", 1'b0, reg2_on);
        reg2_enable_n = 1'b1;
        step(1000);
        reg2_enable_n = 1'b0;
        step(2);
        check("reg2 rebooted", 1'b1, reg2_on);
        $display("reg2 undervoltage test done");
    endtask

    task automatic test_reg1_ss();
        do_reset();
        reg1_uv = 1'b1;
        step(300);
        check("reg1 ss busy", 1'b0, reg1_ss_done);
        check("reg1 uv ignored", 1'b1, reg1_on);
        check("aux uv ignored", 1'b1, aux_on);
        reg1_uv = 1'b0;
        $display("reg1 soft start test done");
    endtask

    // ---------------------------------------------
    // Main sequence
    // ---------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        sleep = 1'b1;
        test_thermal();
        test_bridge();
        test_reg1_oc();
        test_reg2_oc();
        test_reg2_uv();
        test_reg1_ss();
        end_of_test();
    end
endmodule

// >>> src/fault_prot.sv
// Purpose: Fault protection for a two-channel bridge and two buck regulators
// Assumes: Comparator flags synchronous to clk, active high
// Notes: rst_b is the power-on reset
`timescale 1ns/10ps
`include "fault_prot_cfg.svh"
module fault_prot
    import fault_prot_pkg::*;
(
    // Clock and power-on reset
    input wire logic clk,
    input wire logic rst_b,
    // Comparator flags
    input wire logic thermal_shutdown,
    input wire logic bridge_oc,
    input wire logic reg1_oc,
    input wire logic reg2_oc,
    input wire logic reg1_uv,
    input wire logic reg2_uv,
    input wire logic reg2_supply_low,
    // Control pins
    input wire logic sleep,
    input wire logic reg1_enable_n,
    input wire logic reg2_enable_n,
    // Switching cycle markers
    input wire logic reg1_cycle_start,
    input wire logic reg2_cycle_start,
    // Enables to output stages, soft-start done flags and overcurrent flag
    output logic bridge_on,
    output logic aux_on,
    output logic reg1_on,
    output logic reg2_on,
    output logic reg2_high_side_ok,
    output logic reg1_ss_done,
    output logic reg2_ss_done,
    output logic overcurrent_flag_out
);
    // ----------------------------------------
    // Timers
    // ----------------------------------------
    fault_tmr_if br_t ();
    fault_tmr_if r1oc_t ();
    fault_tmr_if r1uv_t ();
    fault_tmr_if r2uv_t ();

    persist_tmr u_br (.clk(clk), .rst_b(rst_b), .t(br_t.timer));
    persist_tmr u_r1oc (.clk(clk), .rst_b(rst_b), .t(r1oc_t.timer));
    persist_tmr u_r1uv (.clk(clk), .rst_b(rst_b), .t(r1uv_t.timer));
    persist_tmr u_r2uv (.clk(clk), .rst_b(rst_b), .t(r2uv_t.timer));

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic tsd_ff, nxt_tsd;
    logic br_lat_ff, nxt_br_lat;
    seq_e sl_seq_ff, nxt_sl_seq;
    logic r1_uv_lat_ff, nxt_r1_uv_lat;
    seq_e e1_seq_ff, nxt_e1_seq;
    logic r2_uv_lat_ff, nxt_r2_uv_lat;
    tmr_t r1_off_ff, nxt_r1_off;
    logic r1_wait_ff, nxt_r1_wait;
    tmr_t r1_ss_ff, nxt_r1_ss;
    tmr_t r2_ss_ff, nxt_r2_ss;
    logic r2_cut_ff, nxt_r2_cut;
    logic r1_run, r2_run;
    tmr_t br_oc_cnt_ff, nxt_br_oc_cnt;

    // Timer requests
    always_comb
    begin
        br_t.run = bridge_oc && !br_lat_ff;
        br_t.limit = tmr_t'(`BR_MASK_CYC);
        r1oc_t.run = reg1_oc && (r1_off_ff == '0) && !r1_wait_ff;
        r1oc_t.limit = tmr_t'(`R1_OC_MASK_CYC);
        r1uv_t.run = reg1_uv && reg1_ss_done && !r1_uv_lat_ff;
        r1uv_t.limit = tmr_t'(`R1_UV_MASK_CYC);
        r2uv_t.run = reg2_uv && reg2_ss_done && !r2_uv_lat_ff;
        r2uv_t.limit = tmr_t'(`R2_UV_CYC);
    end

    // Fault latches and restart sequences
    always_comb
    begin
        nxt_tsd = tsd_ff || thermal_shutdown;
        nxt_sl_seq = sl_seq_ff;
        nxt_br_lat = br_lat_ff || br_t.done;
        if (br_lat_ff)
        begin
            // high -> low -> high on sleep
            unique case (sl_seq_ff)
                SEQ_IDLE: if (sleep) nxt_sl_seq = SEQ_ONE;
                SEQ_ONE: if (!sleep) nxt_sl_seq = SEQ_TWO;
                SEQ_TWO: if (sleep)
                begin
                    nxt_br_lat = 1'b0;
                    nxt_sl_seq = SEQ_IDLE;
                end
                default: nxt_sl_seq = SEQ_IDLE;
            endcase
        end
        else
            nxt_sl_seq = SEQ_IDLE;
        nxt_e1_seq = e1_seq_ff;
        nxt_r1_uv_lat = r1_uv_lat_ff || r1uv_t.done;
        if (r1_uv_lat_ff)
        begin
            // low -> high -> low on enable
            unique case (e1_seq_ff)
                SEQ_IDLE: if (!reg1_enable_n) nxt_e1_seq = SEQ_ONE;
                SEQ_ONE: if (reg1_enable_n) nxt_e1_seq = SEQ_TWO;
                SEQ_TWO: if (!reg1_enable_n)
                begin
                    nxt_r1_uv_lat = 1'b0;
                    nxt_e1_seq = SEQ_IDLE;
                end
                default: nxt_e1_seq = SEQ_IDLE;
            endcase
        end
        else
            nxt_e1_seq = SEQ_IDLE;
        // enable high clears the regulator 2 latch
        nxt_r2_uv_lat = (r2_uv_lat_ff && !reg2_enable_n) || r2uv_t.done;
    end

    // Regulator timers: off interval, soft starts, cycle cut
    always_comb
    begin
        nxt_r1_off = r1_off_ff;
        nxt_r1_wait = r1_wait_ff;
        if (r1oc_t.done)
            nxt_r1_off = tmr_t'(`R1_OFF_CYC);
        else if (r1_off_ff != '0)
        begin
            nxt_r1_off = r1_off_ff - tmr_t'(1);
            if (r1_off_ff == tmr_t'(1))
                nxt_r1_wait = 1'b1;
        end
        else if (r1_wait_ff && reg1_cycle_start)
            nxt_r1_wait = 1'b0;
        nxt_r1_ss = r1_ss_ff;
        if (!r1_run)
            nxt_r1_ss = '0;
        else if (r1_ss_ff < tmr_t'(`R1_SS_CYC))
            nxt_r1_ss = r1_ss_ff + tmr_t'(1);
        nxt_r2_ss = r2_ss_ff;
        if (!r2_run)
            nxt_r2_ss = '0;
        else if (r2_ss_ff < tmr_t'(`R2_SS_CYC))
            nxt_r2_ss = r2_ss_ff + tmr_t'(1);
        nxt_r2_cut = r2_cut_ff;
        if (reg2_oc)
            nxt_r2_cut = 1'b1;
        else if (reg2_cycle_start)
            nxt_r2_cut = 1'b0;
    end

    // Registers
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tsd_ff <= 1'b0;
            br_lat_ff <= 1'b0;
            sl_seq_ff <= SEQ_IDLE;
            r1_uv_lat_ff <= 1'b0;
            e1_seq_ff <= SEQ_IDLE;
            r2_uv_lat_ff <= 1'b0;
            r1_off_ff <= '0;
            r1_wait_ff <= 1'b0;
            r1_ss_ff <= '0;
            r2_ss_ff <= '0;
            r2_cut_ff <= 1'b0;
        end
        else
        begin
            tsd_ff <= nxt_tsd;
            br_lat_ff <= nxt_br_lat;
            sl_seq_ff <= nxt_sl_seq;
            r1_uv_lat_ff <= nxt_r1_uv_lat;
            e1_seq_ff <= nxt_e1_seq;
            r2_uv_lat_ff <= nxt_r2_uv_lat;
            r1_off_ff <= nxt_r1_off;
            r1_wait_ff <= nxt_r1_wait;
            r1_ss_ff <= nxt_r1_ss;
            r2_ss_ff <= nxt_r2_ss;
            r2_cut_ff <= nxt_r2_cut;
        end
    end

    // ----------------------------------------
    // Output gating
    // ----------------------------------------
    assign r1_run = !tsd_ff && !reg1_enable_n && !r1_uv_lat_ff;
    assign r2_run = !tsd_ff && !reg2_enable_n && !r2_uv_lat_ff && !reg2_supply_low;
    assign reg1_ss_done = r1_ss_ff >= tmr_t'(`R1_SS_CYC);
    assign reg2_ss_done = r2_ss_ff >= tmr_t'(`R2_SS_CYC);
    assign bridge_on = !tsd_ff && !br_lat_ff && !r1_uv_lat_ff;
    assign aux_on = !tsd_ff && !r1_uv_lat_ff;
    assign reg1_on = r1_run && (r1_off_ff == '0) && !r1_wait_ff;
    assign reg2_on = r2_run;
    assign reg2_high_side_ok = r2_run && !r2_cut_ff && !reg2_oc;
    assign overcurrent_flag_out = !br_lat_ff;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_tsd_off: assert property (@(posedge clk) disable iff (!rst_b)
        thermal_shutdown |=> !bridge_on && !reg1_on && !reg2_on && !aux_on)
        else $error("Outputs on after thermal trip");
    chk_tsd_hold: assert property (@(posedge clk) disable iff (!rst_b)
        tsd_ff |=> tsd_ff)
        else $error("Thermal latch released without reset");
    // Check helper: run length of unlatched bridge overcurrent, saturating
    always_comb
    begin
        nxt_br_oc_cnt = '0;
        if (bridge_oc && !br_lat_ff && (br_oc_cnt_ff != '1))
            nxt_br_oc_cnt = br_oc_cnt_ff + tmr_t'(1);
        else if (bridge_oc && !br_lat_ff)
            nxt_br_oc_cnt = br_oc_cnt_ff;
    end

    // Check helper register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            br_oc_cnt_ff <= '0;
        else
            br_oc_cnt_ff <= nxt_br_oc_cnt;
    end

    // Overcurrent still present after a full mask of earlier samples
    sequence br_oc_held;
        bridge_oc && !br_lat_ff && (br_oc_cnt_ff >= tmr_t'(`BR_MASK_CYC));
    endsequence
    chk_br_latch: assert property (@(posedge clk) disable iff (!rst_b)
        br_oc_held |=> br_lat_ff)
        else $error("Bridge latch missed after mask");
    chk_br_mask: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(bridge_oc) && !br_lat_ff |=> !br_lat_ff [*8])
        else $error("Bridge latch before mask");
    chk_br_clear: assert property (@(posedge clk) disable iff (!rst_b)
        br_lat_ff && !sleep |=> br_lat_ff)
        else $error("Bridge latch cleared with sleep low");
    chk_flag_bridge: assert property (@(posedge clk) disable iff (!rst_b)
        !overcurrent_flag_out |-> !bridge_on)
        else $error("Flag low while bridge on");
    chk_r1_off: assert property (@(posedge clk) disable iff (!rst_b)
        r1oc_t.done |=> !reg1_on [*8])
        else $error("Regulator 1 on during off interval");
    chk_r1_resume: assert property (@(posedge clk) disable iff (!rst_b)
        r1_wait_ff && !reg1_cycle_start |=> r1_wait_ff)
        else $error("Regulator 1 resumed off cycle edge");
    chk_r2_cut: assert property (@(posedge clk) disable iff (!rst_b)
        reg2_oc && !reg2_cycle_start |=> !reg2_high_side_ok)
        else $error("High side on after limit");
    chk_r1_uv: assert property (@(posedge clk) disable iff (!rst_b)
        r1uv_t.done |=> r1_uv_lat_ff && !reg1_on && !aux_on)
        else $error("Regulator 1 undervoltage latch missed");
    chk_r1_ss: assert property (@(posedge clk) disable iff (!rst_b)
        !reg1_ss_done |=> $stable(r1_uv_lat_ff) || !r1_uv_lat_ff)
        else $error("Undervoltage latched in soft start");
    chk_r2_lock: assert property (@(posedge clk) disable iff (!rst_b)
        reg2_supply_low |-> !reg2_on)
        else $error("Regulator 2 on under lockout");
endmodule

// >>> src/fault_prot_cfg.svh
// Purpose: Constants for the motor/regulator fault protection block
// Assumes: 10 MHz core clock, 100 ns period
// Notes: Times in their own unit, cycle counts derived from them
//
// What this block does
// - Overtemperature switches every output stage enable off at once, no auto recovery; overcurrent flag unaffected.
// - After thermal shutdown, outputs return only after a power-on reset.
// - Bridge overcurrent waits a 3 us mask, then latches bridge outputs off.
// - Bridge overcurrent latch clears only on sleep high, low, high.
// - Overcurrent flag output goes low as the bridge latch switches off.
// - Regulator 1 overcurrent past 0.15 us mask forces it off 256 us.
// - After that off interval regulator 1 resumes at next turn-on edge.
// - Regulator 2 high side is cut for rest of period at current limit.
// - Regulator 1 undervoltage held through 10 us mask latches it off.
// - Regulator 1 undervoltage latch also turns off the bridge and aux outputs; the overcurrent flag is unaffected.
// - Regulator 1 undervoltage latch clears on enable low, high, low.
// - Regulator 1 undervoltage ignored until soft-start count of 16.4 ms ends.
// - Regulator 2 undervoltage held 1 ms turns it off; enable cycle restarts.
// - Regulator 2 soft start begins with enable low and reset released.
// - Regulator 2 held off while its supply lockout flag is asserted.
`ifndef FAULT_PROT_CFG_SVH
`define FAULT_PROT_CFG_SVH

`define CLK_HZ 10000000
`define BR_MASK_NS 3000
`define BR_MASK_CYC ((`BR_MASK_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define R1_OC_MASK_NS 150
`define R1_OC_MASK_CYC ((`R1_OC_MASK_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define R1_OFF_US 256
`define R1_OFF_CYC (`R1_OFF_US * (`CLK_HZ / 1000000))
`define R1_UV_MASK_US 10
`define R1_UV_MASK_CYC (`R1_UV_MASK_US * (`CLK_HZ / 1000000))
`define R1_SS_US 16400
`define R1_SS_CYC (`R1_SS_US * (`CLK_HZ / 1000000))
`define R2_UV_US 1000
`define R2_UV_CYC (`R2_UV_US * (`CLK_HZ / 1000000))
`define R2_SS_US 1000
`define R2_SS_CYC (`R2_SS_US * (`CLK_HZ / 1000000))
`define TMR_W 18

`endif

// >>> src/fault_prot_pkg.sv
// Purpose: Types shared by the fault protection modules
// Assumes: Timer width from the config header
// Notes: None
package fault_prot_pkg;
`include "fault_prot_cfg.svh"
    typedef logic [`TMR_W-1:0] tmr_t;
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ONE = 2'b01,
        SEQ_TWO = 2'b10
    } seq_e;
endpackage

// >>> src/fault_tmr_if.sv
// Purpose: Carries a persistence timer request and its result
// Assumes: Single clock domain
// Notes: None
`timescale 1ns/10ps
interface fault_tmr_if;
    import fault_prot_pkg::*;
    logic run;
    tmr_t limit;
    logic done;
    modport owner (output run, output limit, input done);
    modport timer (input run, input limit, output done);
endinterface

// >>> src/persist_tmr.sv
// Purpose: Counts while run is high, flags done once limit is reached
// Assumes: Run dropping clears the count
// Notes: Done stays high while run holds after the limit
`timescale 1ns/10ps
module persist_tmr
    import fault_prot_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Timer request
    fault_tmr_if.timer t
);
    tmr_t cnt_ff;
    tmr_t nxt_cnt;

    // Next count: saturate at limit, clear when run drops
    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (!t.run)
            nxt_cnt = '0;
        else if (cnt_ff < t.limit)
            nxt_cnt = cnt_ff + tmr_t'(1);
    end

    // Count register
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_ff <= '0;
        else
            cnt_ff <= nxt_cnt;
    end

    assign t.done = t.run && (cnt_ff >= t.limit);
endmodule
